/* File: src/clk_pkg.sv */
// Constants and types shared by the clock source and distribution block.
package clk_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses on the APB port)
	// ------------------------------------------------------------
	localparam int          ADDR_W     = 8;
	localparam logic [7:0]  OFF_MAIN   = 8'h00;
	localparam logic [7:0]  OFF_PLL    = 8'h04;
	localparam logic [7:0]  OFF_PSTAT  = 8'h08;
	localparam logic [7:0]  OFF_DBL    = 8'h0c;
	localparam logic [7:0]  OFF_MASTER = 8'h10;
	localparam logic [7:0]  OFF_SLOW   = 8'h14;
	localparam logic [7:0]  OFF_FAST   = 8'h18;
	localparam logic [5:0]  DIV_IDX_LO = 6'h08;
	localparam logic [5:0]  DIV_IDX_HI = 6'h14;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int PLL_P_LSB  = 3;
	localparam int PLL_Q_LSB  = 11;
	localparam int BUS_LSB    = 4;
	localparam int CPU_LSB    = 20;
	localparam int SLOW_CMD   = 31;
	localparam int SLOW_CNT   = 16;
	localparam int FAST_CNT   = 8;
	localparam int DSRC_LSB   = 16;

	// ------------------------------------------------------------
	// Sources, sizes and reset values
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SRC_MAIN  = 3'h0,
		SRC_XTAL  = 3'h1,
		SRC_ICON  = 3'h2,
		SRC_PLL   = 3'h3,
		SRC_LSO   = 3'h4,
		SRC_WATCH = 3'h5,
		SRC_DBL   = 3'h6,
		SRC_OFF   = 3'h7
	} src_t;
	localparam int          N_DIV     = 12;
	localparam int          SLOW_W    = 13;
	localparam int          FAST_W    = 5;
	localparam logic [2:0]  FREQ_MAX  = 3'h5;
	localparam logic [2:0]  FREQ_RST  = 3'h2;
	localparam logic [7:0]  PLL_P_MIN = 8'h04;
	localparam logic [15:0] BUS_RST   = 16'h0002;
	localparam logic [3:0]  CPU_RST   = 4'h2;
	localparam logic [15:0] DIV_RST   = 16'h0002;
	localparam logic [1:0]  DIV33     = 2'h3;
	localparam logic [6:0]  DIV1K     = 7'h64;
	localparam int          LOCK_NS   = 250000;
	localparam int          MCLK_NS   = 10;
	localparam int          LOCK_CYC  = LOCK_NS / MCLK_NS;

endpackage

/* File: src/clk_top.sv */
// Clock sources, low-speed tick counters and clock dividers with an APB register port.
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Glitch-free divider, resynchronised to mclk
// ------------------------------------------------------------
module clk_div #(
	parameter int W = 16
) (
	input  wire logic         mclk,
	input  wire logic         rst_b,
	input  wire logic [7:0]   src_ev,
	input  wire logic [2:0]   sel,
	input  wire logic [W-1:0] div,
	output var  logic         clk_o,
	output var  logic         rise_o
);
	import clk_pkg::*;

	logic [2:0]   sel_r;
	logic [W-1:0] div_r;
	logic [W-1:0] cnt_r;

	// New settings are only taken at the end of a period or while the source is off, so no short pulse escapes.
	wire [W-1:0] lim     = (div < W'(2)) ? W'(2) : div;
	wire         ev      = src_ev[sel_r];
	wire         idle    = (sel_r == SRC_OFF);
	wire         wrap    = ev && (cnt_r >= div_r - W'(1));
	wire [W-1:0] cnt_nxt = wrap ? '0 : cnt_r + W'(1);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sel_r  <= SRC_OFF;
			div_r  <= W'(2);
			cnt_r  <= '0;
			clk_o  <= 1'b0;
			rise_o <= 1'b0;
		end else begin
			rise_o <= wrap;
			if (wrap || idle) begin
				sel_r <= sel;
				div_r <= lim;
			end
			if (ev)
				cnt_r <= cnt_nxt;
			if (wrap)
				clk_o <= 1'b1;
			else if (ev && cnt_nxt == (div_r >> 1))
				clk_o <= 1'b0;
		end
	end
endmodule // clk_div

module clk_top #(
	parameter int          LOCK_CYCLES = clk_pkg::LOCK_CYC,
	parameter logic [47:0] TRIM_TABLE  = 48'h807060504030
) (
	input  wire logic                        mclk,
	input  wire logic                        rst_b,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [clk_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [31:0]                 pwdata,
	output var  logic [31:0]                 prdata,
	output var  logic                        pready,
	output var  logic                        pslverr,
	input  wire logic                        main_osc_clk,
	input  wire logic                        fast_crystal_osc_clk,
	input  wire logic                        interconnect_clk,
	input  wire logic                        pll_core_clk,
	input  wire logic                        low_speed_internal_osc_clk,
	input  wire logic                        watch_crystal_osc_clk,
	input  wire logic                        hibernate,
	input  wire logic                        debug_halt,
	output var  logic [2:0]                  main_osc_freq,
	output var  logic [7:0]                  main_osc_trim,
	output var  logic                        pll_en,
	output var  logic [1:0]                  pll_ref_sel,
	output var  logic [7:0]                  pll_p,
	output var  logic [3:0]                  pll_q,
	output var  logic                        pll_lock,
	output var  logic                        usb_tick,
	output var  logic                        tick_1k_clock,
	output var  logic                        tick_33k_clock,
	output var  logic                        tick_100k_clock,
	output var  logic                        slow_tick_irq,
	output var  logic                        slow_tick_wake,
	output var  logic                        fast_tick_irq,
	output var  logic                        bus_clk,
	output var  logic                        cpu_clk,
	output var  logic [clk_pkg::N_DIV-1:0]   div_clk
);
	import clk_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	localparam int LW = $clog2(LOCK_CYCLES + 1);

	logic [5:0]        s1_r;
	logic [5:0]        s2_r;
	logic [5:0]        s3_r;
	logic [2:0]        freq_r;
	logic [14:0]       pll_r;
	logic [LW-1:0]     lock_cnt_r;
	logic [2:0]        dbl_r;
	logic [23:0]       master_r;
	logic [5:0]        slow_cfg_r;
	logic [5:0]        fast_cfg_r;
	logic [18:0]       div_cfg_r [N_DIV];
	logic [SLOW_W-1:0] slow_cnt_r;
	logic [FAST_W-1:0] fast_cnt_r;
	logic [1:0]        c33_r;
	logic [6:0]        c1k_r;
	logic              bus_rise;
	logic              cpu_rise;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	wire         setup   = psel && !penable;
	wire         wr      = psel && penable && pwrite && pready;
	wire         div_hit = (paddr[7:2] >= DIV_IDX_LO) && (paddr[7:2] < DIV_IDX_HI) && (paddr[1:0] == 2'h0);
	wire [3:0]   div_idx = 4'(paddr[7:2] - DIV_IDX_LO);
	wire         known   = hit(paddr, OFF_MAIN) || hit(paddr, OFF_PLL) || hit(paddr, OFF_PSTAT)
		|| hit(paddr, OFF_DBL) || hit(paddr, OFF_MASTER) || hit(paddr, OFF_SLOW)
		|| hit(paddr, OFF_FAST) || div_hit;
	wire         wr_pll  = wr && hit(paddr, OFF_PLL);
	wire         wr_slow = wr && hit(paddr, OFF_SLOW);
	wire [7:0]   p_wr    = pwdata[PLL_P_LSB +: 8];
	wire [7:0]   p_cl    = (p_wr < PLL_P_MIN) ? PLL_P_MIN : p_wr;
	wire [14:0]  pll_nxt = {pwdata[PLL_Q_LSB +: 4], p_cl, pwdata[2:0]};
	wire [31:0]  rd_div  = {13'h0, div_cfg_r[div_idx]};
	wire [31:0]  rd_w    =
		hit(paddr, OFF_MAIN)   ? {16'h0, main_osc_trim, 5'h0, freq_r} :
		hit(paddr, OFF_PLL)    ? {17'h0, pll_r} :
		hit(paddr, OFF_PSTAT)  ? {31'h0, pll_lock} :
		hit(paddr, OFF_DBL)    ? {29'h0, dbl_r} :
		hit(paddr, OFF_MASTER) ? {8'h0, master_r} :
		hit(paddr, OFF_SLOW)   ? {3'h0, slow_cnt_r, 10'h0, slow_cfg_r} :
		hit(paddr, OFF_FAST)   ? {19'h0, fast_cnt_r, 2'h0, fast_cfg_r} :
		div_hit                ? rd_div : 32'h0;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata  <= pwrite ? 32'h0 : rd_w;
				pslverr <= !known;
			end
		end
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			freq_r     <= FREQ_RST;
			pll_r      <= {4'h0, PLL_P_MIN, 3'h0};
			dbl_r      <= 3'h0;
			master_r   <= {CPU_RST, BUS_RST, 1'b0, SRC_MAIN};
			slow_cfg_r <= 6'h0;
			fast_cfg_r <= 6'h0;
		end else if (wr) begin
			if (hit(paddr, OFF_MAIN) && pwdata[2:0] <= FREQ_MAX)
				freq_r <= pwdata[2:0];
			if (wr_pll)
				pll_r <= pll_nxt;
			if (hit(paddr, OFF_DBL))
				dbl_r <= pwdata[2:0];
			if (hit(paddr, OFF_MASTER))
				master_r <= pwdata[23:0];
			if (wr_slow)
				slow_cfg_r <= pwdata[5:0];
			if (hit(paddr, OFF_FAST))
				fast_cfg_r <= pwdata[5:0];
		end
	end

	generate
		for (genvar i = 0; i < N_DIV; i++) begin : g_cfg
			always_ff @(posedge mclk or negedge rst_b) begin
				if (!rst_b)
					div_cfg_r[i] <= {SRC_OFF, DIV_RST};
				else if (wr && div_hit && div_idx == 4'(i))
					div_cfg_r[i] <= pwdata[18:0];
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Main oscillator trim and PLL lock
	// ------------------------------------------------------------
	assign main_osc_freq = freq_r;
	assign pll_en        = pll_r[0];
	assign pll_ref_sel   = pll_r[2:1];
	assign pll_p         = pll_r[PLL_P_LSB +: 8];
	assign pll_q         = pll_r[PLL_Q_LSB +: 4];

	// Lock is only believed after the full worst-case lock time.
	wire lock_done = (lock_cnt_r == LW'(LOCK_CYCLES - 1));

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			main_osc_trim <= 8'h0;
			lock_cnt_r    <= '0;
			pll_lock      <= 1'b0;
		end else begin
			main_osc_trim <= TRIM_TABLE[freq_r * 8 +: 8];
			if (!pll_r[0] || (wr_pll && pll_nxt != pll_r)) begin
				lock_cnt_r <= '0;
				pll_lock   <= 1'b0;
			end else if (!pll_lock) begin
				lock_cnt_r <= lock_cnt_r + LW'(1);
				pll_lock   <= lock_done;
			end
		end
	end

	// ------------------------------------------------------------
	// Source synchronisers and doubler
	// ------------------------------------------------------------
	wire [5:0] raw = {watch_crystal_osc_clk, low_speed_internal_osc_clk, pll_core_clk,
		interconnect_clk, fast_crystal_osc_clk, main_osc_clk};
	wire [5:0] rise_w = s2_r & ~s3_r;
	wire [5:0] edge_w = s2_r ^ s3_r;
	// Both edges of the chosen input give twice its rate in events.
	wire       dbl_ev = dbl_r[0] && (dbl_r[2:1] != 2'h3) && edge_w[dbl_r[2:1]];
	wire [7:0] src_ev = {1'b0, dbl_ev, rise_w};
	wire       lso_ev = rise_w[SRC_LSO];

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s1_r     <= 6'h0;
			s2_r     <= 6'h0;
			s3_r     <= 6'h0;
			usb_tick <= 1'b0;
		end else begin
			s1_r     <= raw;
			s2_r     <= s1_r;
			s3_r     <= s2_r;
			usb_tick <= dbl_ev;
		end
	end

	// ------------------------------------------------------------
	// Low-speed clocks and tick counters
	// ------------------------------------------------------------
	wire                ev1k     = lso_ev && (c1k_r == DIV1K - 7'h1);
	wire                run      = !hibernate && !debug_halt;
	wire                adv      = ev1k && run;
	wire [SLOW_W-1:0]   slow_nxt = slow_cnt_r + SLOW_W'(1);
	wire [SLOW_W-1:0]   mask     = SLOW_W'((14'h1 << slow_cfg_r[3:0]) - 14'h1);
	wire                period   = adv && ((slow_nxt & mask) == '0);
	wire                fast_tc  = lso_ev && (fast_cnt_r == fast_cfg_r[4:0]);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			c33_r           <= 2'h0;
			c1k_r           <= 7'h0;
			tick_33k_clock  <= 1'b0;
			tick_1k_clock   <= 1'b0;
			tick_100k_clock <= 1'b0;
		end else begin
			tick_100k_clock <= s3_r[SRC_LSO];
			if (lso_ev) begin
				c33_r          <= (c33_r == DIV33 - 2'h1) ? 2'h0 : c33_r + 2'h1;
				tick_33k_clock <= (c33_r == DIV33 - 2'h1);
				c1k_r          <= ev1k ? 7'h0 : c1k_r + 7'h1;
				tick_1k_clock  <= ev1k || (c1k_r < (DIV1K >> 1) - 7'h1);
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			slow_cnt_r     <= '0;
			fast_cnt_r     <= '0;
			slow_tick_irq  <= 1'b0;
			slow_tick_wake <= 1'b0;
			fast_tick_irq  <= 1'b0;
		end else begin
			if (wr_slow && pwdata[SLOW_CMD])
				slow_cnt_r <= '0;
			else if (adv)
				slow_cnt_r <= slow_nxt;
			slow_tick_irq  <= period && slow_cfg_r[4];
			slow_tick_wake <= period && slow_cfg_r[5];
			if (fast_tc)
				fast_cnt_r <= '0;
			else if (lso_ev)
				fast_cnt_r <= fast_cnt_r + FAST_W'(1);
			fast_tick_irq <= fast_tc && fast_cfg_r[5];
		end
	end

	// ------------------------------------------------------------
	// Bus, CPU and general dividers
	// ------------------------------------------------------------
	wire master_ev = src_ev[master_r[2:0]];

	clk_div #(.W(16)) u_bus (
		.mclk   (mclk),
		.rst_b  (rst_b),
		.src_ev ({7'h0, master_ev}),
		.sel    (SRC_MAIN),
		.div    (master_r[BUS_LSB +: 16]),
		.clk_o  (bus_clk),
		.rise_o (bus_rise)
	);

	clk_div #(.W(4)) u_cpu (
		.mclk   (mclk),
		.rst_b  (rst_b),
		.src_ev ({7'h0, bus_rise}),
		.sel    (SRC_MAIN),
		.div    (master_r[CPU_LSB +: 4]),
		.clk_o  (cpu_clk),
		.rise_o (cpu_rise)
	);

	generate
		for (genvar i = 0; i < N_DIV; i++) begin : g_div
			clk_div #(.W(16)) u_div (
				.mclk   (mclk),
				.rst_b  (rst_b),
				.src_ev (src_ev),
				.sel    (div_cfg_r[i][DSRC_LSB +: 3]),
				.div    (div_cfg_r[i][15:0]),
				.clk_o  (div_clk[i]),
				.rise_o ()
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sequence apb_setup;
		psel && !penable;
	endsequence
	sequence apb_answer;
		pready && psel && penable;
	endsequence

	a_apb_one_wait: assert property (apb_setup ##1 penable |-> apb_answer)
		else $error("pready missing in access phase");
	a_pll_lock_time: assert property ($rose(pll_lock) |-> $past(lock_done))
		else $error("lock before lock time");
	a_pll_lock_clr: assert property (wr_pll && pll_nxt != pll_r |=> !pll_lock [*2])
		else $error("lock kept after reconfiguration");
	a_pll_off_nolock: assert property (!pll_en |=> !pll_lock)
		else $error("lock set while disabled");
	a_slow_reset_zero: assert property (wr_slow && pwdata[SLOW_CMD] |=> slow_cnt_r == '0)
		else $error("slow tick not cleared");
	a_slow_halt_hold: assert property (!run && !wr_slow |=> $stable(slow_cnt_r))
		else $error("slow tick moved while halted");
	a_fast_tc_wrap: assert property (fast_tc |=> fast_cnt_r == '0)
		else $error("fast tick did not restart");
	a_fast_irq_cause: assert property (fast_tick_irq |-> $past(fast_tc && fast_cfg_r[5]))
		else $error("fast tick interrupt without cause");
	a_div3_period: assert property (lso_ev && c33_r == 2'h2 |=> c33_r == 2'h0 && tick_33k_clock)
		else $error("33 kHz divider wrong");
	a_cpu_from_bus: assert property (cpu_rise |-> $past(bus_rise))
		else $error("cpu clock edge without bus edge");

endmodule // clk_top

`default_nettype wire

/* File: tb/clk_src_model.sv */
// Free-running raw source oscillators feeding the clock block.
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Source oscillators
// ------------------------------------------------------------
// Half periods in ns: main, crystal, interconnect, pll, low speed, watch.
// Edges sit 3 ns off the mclk grid so that sampling never races a source edge.
module clk_src_model #(
	parameter logic [47:0] HALVES = {8'd70, 8'd30, 8'd50, 8'd80, 8'd60, 8'd40}
) (
	output var logic [5:0] src
);
	for (genvar g = 0; g < 6; g++) begin : g_osc
		initial begin
			src[g] = 1'b0;
			#3;
			forever #(HALVES[8*g +: 8]) src[g] = ~src[g];
		end
	end
endmodule // clk_src_model

`default_nettype wire

/* File: tb/clock_sources_and_timewheels_test.sv */
// Self-checking bench for the clock sources, tick counters and dividers.
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_fail++; \
	$display("ERROR %s expected %0h seen %0h", nm, ex, got); end end

module clock_sources_and_timewheels_test;
	import clk_pkg::*;
	localparam logic [47:0] TRIM = 48'h5a4b3c2d1e0f;
	localparam int LSO = 6;
	logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr, er;
	logic        hibernate, debug_halt, pll_lock, usb_tick, f_irq, pll_en;
	logic [1:0]  pll_ref;
	logic [7:0]  paddr, trim, pll_p;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0]  freq;
	logic [3:0]  pll_q;
	logic [11:0] dclk;
	logic [5:0]  src;
	logic [9:0]  mon;
	int          n_fail = 0, compares = 0, cyc = 0, p, h, n, k, b;
	int          per [6] = '{8, 12, 16, 10, 6, 14};

	clk_src_model osc (.src(src));
	clk_top #(.LOCK_CYCLES(20), .TRIM_TABLE(TRIM)) dut (
		.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.main_osc_clk(src[0]), .fast_crystal_osc_clk(src[1]), .interconnect_clk(src[2]),
		.pll_core_clk(src[3]), .low_speed_internal_osc_clk(src[4]), .watch_crystal_osc_clk(src[5]),
		.hibernate(hibernate), .debug_halt(debug_halt), .main_osc_freq(freq), .main_osc_trim(trim),
		.pll_en(pll_en), .pll_ref_sel(pll_ref), .pll_p(pll_p), .pll_q(pll_q), .pll_lock(pll_lock),
		.usb_tick(usb_tick), .tick_1k_clock(mon[8]), .tick_33k_clock(mon[0]), .tick_100k_clock(mon[9]),
		.slow_tick_irq(mon[6]), .slow_tick_wake(mon[7]), .fast_tick_irq(f_irq),
		.bus_clk(mon[1]), .cpu_clk(mon[2]), .div_clk(dclk));
	assign mon[5:3] = {f_irq, dclk[11], dclk[0]};

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// ------------------------------------------------------------
	// Bus and measurement tasks
	// ------------------------------------------------------------
	// One idle edge closes every transfer so that no strobe is driven twice in a step.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int j;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		j = 0;
		do begin
			@(posedge mclk);
			j++;
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		`CHK("pready_wait", 1, j)
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic chkrd(input logic [7:0] a, input logic [31:0] ex);
		apb(1'b0, a, 32'h0);
		`CHK("prdata", ex, rd)
		`CHK("pslverr", 1'b0, er)
	endtask

	task automatic rise(input int i);
		int j;
		j = 0;
		while (mon[i] !== 1'b0 && j < 3000) begin
			@(posedge mclk);
			j++;
		end
		while (mon[i] !== 1'b1 && j < 3000) begin
			@(posedge mclk);
			j++;
		end
	endtask

	// Second call only: the first period may still run on the old setting.
	task automatic meas(input int i);
		rise(i);
		rise(i);
		p = 0;
		h = 0;
		while (mon[i] === 1'b1 && p < 3000) begin
			@(posedge mclk);
			p++;
			h++;
		end
		while (mon[i] !== 1'b1 && p < 3000) begin
			@(posedge mclk);
			p++;
		end
	endtask

	task automatic span(output int d);
		apb(1'b0, OFF_SLOW, 32'h0);
		d = int'(rd[28:16]);
		// Setup edges exactly 1200 cycles apart, so the count of 1 kHz ticks is phase free.
		repeat (1197) @(posedge mclk);
		apb(1'b0, OFF_SLOW, 32'h0);
		d = int'(rd[28:16]) - d;
	endtask

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			close_out();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, paddr, pwdata, hibernate, debug_halt, rst_b} = '0;
		void'($urandom(32'ha0d92036));
		repeat (5) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		`CHK("pll_p", 8'h04, pll_p)
		chkrd(OFF_MASTER, 32'h00200020);
		for (int c = 0; c <= 6; c++) begin
			n = (c > 5) ? 5 : c;
			wr(OFF_MAIN, 32'(c));
			@(posedge mclk);
			`CHK("freq", n[2:0], freq)
			`CHK("trim", TRIM[8*n +: 8], trim)
			chkrd(OFF_MAIN, {16'h0, TRIM[8*n +: 8], 5'h0, n[2:0]});
		end
		foreach (per[i]) begin
			apb(1'b0, 8'h50 + 8'(i * 35), 32'h0);
			`CHK("unmapped", 33'h100000000, {er, rd})
		end
		done("registers");
		for (int t = 0; t < 3; t++) begin
			n = (t == 0) ? 1 : $urandom % 256;
			k = $urandom % 16;
			wr(OFF_PLL, 32'(1 | (t << 1) | (n << 3) | (k << 11)));
			@(posedge mclk);
			`CHK("lock_clear", 1'b0, pll_lock)
			`CHK("pll_p", 8'((n < 4) ? 4 : n), pll_p)
			`CHK("pll_q", k[3:0], pll_q)
			`CHK("pll_en", 1'b1, pll_en)
			`CHK("pll_ref", t[1:0], pll_ref)
			repeat (10) @(posedge mclk);
			`CHK("lock_early", 1'b0, pll_lock)
			repeat (20) @(posedge mclk);
			`CHK("lock", 1'b1, pll_lock)
			chkrd(OFF_PSTAT, 32'h1);
		end
		wr(OFF_PLL, 32'h0);
		@(posedge mclk);
		`CHK("lock_off", 1'b0, pll_lock)
		`CHK("pll_en_off", 1'b0, pll_en)
		done("pll");
		for (int s = 0; s < 3; s++) begin
			wr(OFF_DBL, 32'(1 | (s << 1)));
			repeat (40) @(posedge mclk);
			n = 0;
			repeat (480) begin
				@(posedge mclk);
				n += (usb_tick === 1'b1);
			end
			`CHK("usb_ticks", 480 / (4 + 2 * s), n)
		end
		done("doubler");
		for (int t = 0; t < 2; t++) begin
			n = t ? 31 : 1 + $urandom % 6;
			wr(OFF_FAST, 32'(32'h20 | n));
			meas(5);
			`CHK("fast_period", (n + 1) * LSO, p)
		end
		meas(0);
		`CHK("t33k_period", 3 * LSO, p)
		`CHK("t33k_high", LSO, h)
		meas(8);
		`CHK("t1k_period", 100 * LSO, p)
		meas(9);
		`CHK("t100k_period", LSO, p)
		`CHK("t100k_high", LSO / 2, h)
		done("low speed");
		b = 2 + $urandom % 3;
		k = 2 + $urandom % 3;
		wr(OFF_MASTER, 32'((k << 20) | (b << 4) | 4));
		meas(1);
		`CHK("bus_period", b * LSO, p)
		meas(2);
		`CHK("cpu_period", k * b * LSO, p)
		foreach (per[s]) begin
			n = (s == 0) ? 0 : 2 + $urandom % 5;
			wr(8'h20, 32'((s << 16) | n));
			wr(8'h4c, 32'((s << 16) | n));
			k = (n < 2) ? 2 : n;
			meas(3);
			`CHK("div_period", k * per[s], p)
			`CHK("div_high", (k / 2) * per[s], h)
			meas(4);
			`CHK("analog_period", k * per[s], p)
		end
		// The doubler still runs on the interconnect source: one event per half period.
		wr(8'h20, 32'((6 << 16) | 3));
		meas(3);
		`CHK("dbl_div_period", 3 * per[2] / 2, p)
		`CHK("dbl_div_high", per[2] / 2, h)
		done("dividers");
		hibernate <= 1'b1;
		wr(OFF_SLOW, 32'h80000000);
		apb(1'b0, OFF_SLOW, 32'h0);
		`CHK("slow_zero", 13'h0, rd[28:16])
		span(n);
		`CHK("slow_hib", 0, n)
		hibernate <= 1'b0;
		debug_halt <= 1'b1;
		span(n);
		`CHK("slow_dbg", 0, n)
		debug_halt <= 1'b0;
		span(n);
		`CHK("slow_run", 2, n)
		for (int e = 0; e < 2; e++) begin
			wr(OFF_SLOW, 32'(32'h30 | e));
			meas(6);
			`CHK("slow_irq", (100 * LSO) << e, p)
			meas(7);
			`CHK("slow_wake", (100 * LSO) << e, p)
		end
		done("slow tick");
		close_out();
	end
endmodule // clock_sources_and_timewheels_test

`default_nettype wire
